/* File: rtl/instr_exec_pkg.sv */
// shared constants and carrier types for the instruction subset executor
package instr_exec_pkg;
   localparam logic [3:0] BRANCH_ZERO_HI = 4'hE;
   localparam logic [3:0] BRANCH_ZERO_SUB = 4'h0;
   localparam logic [6:0] CALL_HI7 = 7'h76;
   localparam logic [3:0] SECOND_WORD_HI = 4'hF;
   localparam logic [15:0] DECIMAL_ADJUST_WORD = 16'h0007;
   localparam logic [15:0] SLEEP_WORD = 16'h0003;
   localparam logic [5:0] DECREMENT_HI6 = 6'h01;
   localparam logic [5:0] SUB_BORROW_HI6 = 6'h15;
   localparam logic [7:0] INDEXED_LIMIT = 8'h5F;
   localparam logic [7:0] ACCESS_SPLIT = 8'h60;
   localparam logic [3:0] ACCESS_HIGH_BANK = 4'hF;
   localparam logic [3:0] BCD_ADJUST = 4'h6;
   localparam logic [3:0] BCD_MAX_DIGIT = 4'h9;
   localparam logic [20:0] PC_RESET = 21'h000000;
   localparam logic [7:0] WATCHDOG_CLEARED = 8'h00;
   localparam logic [20:0] PC_STEP = 21'h000002;
   localparam logic [20:0] CALL_RETURN_STEP = 21'h000004;
   localparam int FLAG_C = 0;
   localparam int FLAG_DC = 1;
   localparam int FLAG_Z = 2;
   localparam int FLAG_OV = 3;
   localparam int FLAG_N = 4;

   typedef enum logic [1:0] {
      Q_DECODE = 2'b00,
      Q_READ = 2'b01,
      Q_PROCESS = 2'b10,
      Q_WRITE = 2'b11
   } quarter_t;

   // data-memory access request
   typedef struct packed {
      logic [11:0] addr;
      logic rd;
      logic wr;
      logic [7:0] wdata;
   } file_req_t;

   // power-management status seen by the rest of the core
   typedef struct packed {
      logic timeout_flag;
      logic powerdown_flag;
      logic sleeping;
   } power_stat_t;
endpackage

/* File: rtl/file_ram.sv */
// small data memory with registered read data
`timescale 1ns/1ps
module file_ram #(
   parameter int AW = 12,
   parameter int DEPTH = 4096
) (
   input wire logic clk,
   input wire logic [AW-1:0] addr,
   input wire logic rd,
   input wire logic wr,
   input wire logic [7:0] wdata,
   output logic [7:0] rdata
);
   logic [7:0] mem [DEPTH];

   always_ff @(posedge clk) begin
      if (wr) begin
         mem[addr] <= wdata;
      end
   end

   always_ff @(posedge clk) begin
      if (rd) begin
         rdata <= mem[addr];
      end
   end
endmodule

/* File: rtl/cpu_instr_subset_exec.sv */
// executes a subset of an 8-bit core's instructions in four quarter phases
// Notes on behaviour
// - branch_on_zero_op: if zero set, pc becomes pc+2+2n, n signed byte
// - branch not taken one cycle; taken writes pc in q4, then a nop cycle
// - call pushes pc+4, loads pc<20:1> from 20-bit literal, optional shadow save, two cycles
// - decimal_adjust_op adds 6 per nibble when above 9 or carry; only carry changes
// - decode fixed adjust word, decrement 0000 01da, subtract 0101 01da
// - file_decrement_op subtracts one, d selects destination, five flags updated
// - subtract_file_borrow_op computes w minus f minus not carry, d selects destination
// - file operations: decode, read, process, write in the four quarters
// - extended mode with a=0 and address up to 95 uses indexed literal offset
// - sleep clears watchdog and postscaler, sets timeout_flag, clears powerdown_flag
// - sleep halts the oscillator, one word, one cycle, entered in q4
// - a second word with ones in its top four bits runs as a nop
// - each instruction cycle spans four clocks, one per quarter
`timescale 1ns/1ps
module cpu_instr_subset_exec
   import instr_exec_pkg::*;
#(
   parameter int WDT_W = 8,
   parameter int POST_W = 7
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [15:0] instr_word,
   input wire logic extended_mode,
   input wire logic [11:0] index_base,
   input wire logic watchdog_wake,
   input wire logic other_wake,
   output logic [20:0] prog_counter,
   output instr_exec_pkg::quarter_t quarter,
   output logic [7:0] working_register,
   output logic [4:0] status_flags,
   output logic [3:0] bank_select_register,
   output logic [7:0] working_shadow,
   output logic [4:0] flags_shadow,
   output logic [3:0] bank_shadow,
   output logic [20:0] return_stack_top,
   output logic [WDT_W-1:0] watchdog_counter,
   output logic [POST_W-1:0] watchdog_postscaler,
   output instr_exec_pkg::power_stat_t power_stat,
   output logic osc_halted
);
   import instr_exec_pkg::*;

   quarter_t q_r;
   logic [20:0] pc_r;
   logic [15:0] ir_r;
   logic [7:0] w_r;
   logic [4:0] st_r;
   logic [3:0] bsr_r;
   logic [7:0] ws_r;
   logic [4:0] ss_r;
   logic [3:0] bs_r;
   logic [20:0] tos_r;
   logic [WDT_W-1:0] wdt_r;
   logic [POST_W-1:0] post_r;
   logic to_r;
   logic pd_r;
   logic sleep_r;
   logic nop_cycle_r;
   logic call2_r;
   logic [7:0] call_lo_r;
   logic [7:0] res_r;
   logic [4:0] res_flags_r;
   logic wake_s1_r;
   logic wake_s2_r;
   logic owake_s1_r;
   logic owake_s2_r;
   logic [7:0] rdata;
   file_req_t req;

   // decode of the latched instruction word
   logic is_bz;
   logic is_call;
   logic is_daw;
   logic is_dec;
   logic is_sub;
   logic is_sleep;
   logic is_second;
   logic dest_f;
   logic acc_bit;
   logic [7:0] faddr;
   logic [11:0] eff_addr;
   logic bz_taken;

   always_comb begin
      is_bz = ir_r[15:12] == BRANCH_ZERO_HI && ir_r[11:8] == BRANCH_ZERO_SUB;
      is_call = ir_r[15:9] == CALL_HI7;
      is_daw = ir_r == DECIMAL_ADJUST_WORD;
      is_dec = ir_r[15:10] == DECREMENT_HI6;
      is_sub = ir_r[15:10] == SUB_BORROW_HI6;
      is_sleep = ir_r == SLEEP_WORD;
      is_second = ir_r[15:12] == SECOND_WORD_HI;
      dest_f = ir_r[9];
      acc_bit = ir_r[8];
      faddr = ir_r[7:0];
      bz_taken = is_bz && st_r[FLAG_Z];
   end

   // effective file address
   always_comb begin
      if (acc_bit) begin
         eff_addr = {bsr_r, faddr};
      end else if (extended_mode && faddr <= INDEXED_LIMIT) begin
         eff_addr = index_base + {4'h0, faddr};
      end else if (faddr < ACCESS_SPLIT) begin
         eff_addr = {4'h0, faddr};
      end else begin
         eff_addr = {ACCESS_HIGH_BANK, faddr};
      end
   end

   always_comb begin
      req.addr = eff_addr;
      req.rd = q_r == Q_READ && !nop_cycle_r && !call2_r && (is_dec || is_sub);
      req.wr = q_r == Q_WRITE && !nop_cycle_r && !call2_r && (is_dec || is_sub) && dest_f;
      req.wdata = res_r;
   end

   file_ram u_ram (
      .clk(clk),
      .addr(req.addr),
      .rd(req.rd),
      .wr(req.wr),
      .wdata(req.wdata),
      .rdata(rdata)
   );

   // wake inputs come from outside the clock domain
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         wake_s1_r <= 1'b0;
         wake_s2_r <= 1'b0;
         owake_s1_r <= 1'b0;
         owake_s2_r <= 1'b0;
      end else begin
         wake_s1_r <= watchdog_wake;
         wake_s2_r <= wake_s1_r;
         owake_s1_r <= other_wake;
         owake_s2_r <= owake_s1_r;
      end
   end

   // quarter sequencer, frozen while asleep
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         q_r <= Q_DECODE;
      end else if (!sleep_r) begin
         q_r <= quarter_t'(q_r + 2'b01);
      end
   end

   // instruction fetch at the end of each cycle
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         ir_r <= 16'h0000;
      end else if (q_r == Q_WRITE && !sleep_r) begin
         ir_r <= instr_word;
      end
   end

   // arithmetic in q3
   logic [8:0] sum9;
   logic [4:0] sum5;
   logic [7:0] op_a;
   logic [7:0] op_b;
   logic cin;
   always_comb begin
      op_a = 8'h00;
      op_b = 8'h00;
      cin = 1'b0;
      if (is_dec) begin
         op_a = rdata;
         op_b = 8'hFE;
         cin = 1'b1;
      end else begin
         op_a = w_r;
         op_b = ~rdata;
         cin = st_r[FLAG_C];
      end
      sum9 = {1'b0, op_a} + {1'b0, op_b} + {8'h00, cin};
      sum5 = {1'b0, op_a[3:0]} + {1'b0, op_b[3:0]} + {4'h0, cin};
   end

   logic [3:0] lo_adj;
   logic [4:0] hi_adj;
   logic daw_hi;
   always_comb begin
      daw_hi = w_r[7:4] > BCD_MAX_DIGIT || st_r[FLAG_C];
      lo_adj = (w_r[3:0] > BCD_MAX_DIGIT || st_r[FLAG_DC]) ? w_r[3:0] + BCD_ADJUST : w_r[3:0];
      hi_adj = daw_hi ? {1'b0, w_r[7:4]} + {1'b0, BCD_ADJUST} : {1'b0, w_r[7:4]};
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         res_r <= 8'h00;
         res_flags_r <= 5'h00;
      end else if (q_r == Q_PROCESS) begin
         if (is_daw) begin
            res_r <= {hi_adj[3:0], lo_adj};
            res_flags_r <= st_r;
            res_flags_r[FLAG_C] <= daw_hi | st_r[FLAG_C];
         end else begin
            res_r <= sum9[7:0];
            res_flags_r[FLAG_C] <= sum9[8];
            res_flags_r[FLAG_DC] <= sum5[4];
            res_flags_r[FLAG_Z] <= sum9[7:0] == 8'h00;
            res_flags_r[FLAG_N] <= sum9[7];
            res_flags_r[FLAG_OV] <= (op_a[7] == op_b[7]) && (sum9[7] != op_a[7]);
         end
      end
   end

   // program counter and multi-cycle sequencing
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         pc_r <= PC_RESET;
         nop_cycle_r <= 1'b0;
         call2_r <= 1'b0;
         call_lo_r <= 8'h00;
         tos_r <= 21'h000000;
      end else if (!sleep_r) begin
         if (q_r == Q_READ && is_call && !call2_r && !nop_cycle_r) begin
            call_lo_r <= ir_r[7:0];
         end
         // pc_r already points one word past the call
         if (q_r == Q_PROCESS && is_call && !call2_r && !nop_cycle_r) begin
            tos_r <= pc_r - PC_STEP + CALL_RETURN_STEP;
         end
         if (q_r == Q_WRITE) begin
            if (nop_cycle_r || call2_r) begin
               nop_cycle_r <= 1'b0;
               call2_r <= 1'b0;
               pc_r <= pc_r + PC_STEP;
            end else if (bz_taken) begin
               pc_r <= pc_r + {{12{ir_r[7]}}, ir_r[7:0], 1'b0};
               nop_cycle_r <= 1'b1;
            end else if (is_call) begin
               pc_r <= {instr_word[11:0], call_lo_r, 1'b0};
               call2_r <= 1'b1;
            end else begin
               pc_r <= pc_r + PC_STEP;
            end
         end
      end
   end

   // working register, flags and shadows written in q4
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         w_r <= 8'h00;
         st_r <= 5'h00;
         bsr_r <= 4'h0;
         ws_r <= 8'h00;
         ss_r <= 5'h00;
         bs_r <= 4'h0;
      end else if (q_r == Q_WRITE && !nop_cycle_r && !call2_r && !sleep_r) begin
         if (is_call && ir_r[8]) begin
            ws_r <= w_r;
            ss_r <= st_r;
            bs_r <= bsr_r;
         end
         if (is_daw) begin
            w_r <= res_r;
            st_r <= res_flags_r;
         end else if (is_dec || is_sub) begin
            st_r <= res_flags_r;
            if (!dest_f) begin
               w_r <= res_r;
            end
         end
      end
   end

   // sleep entry and wake
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         sleep_r <= 1'b0;
         to_r <= 1'b1;
         pd_r <= 1'b1;
         wdt_r <= '0;
         post_r <= '0;
      end else if (sleep_r) begin
         if (wake_s2_r) begin
            sleep_r <= 1'b0;
            to_r <= 1'b0;
         end else if (owake_s2_r) begin
            sleep_r <= 1'b0;
         end
      end else if (q_r == Q_WRITE && is_sleep && !nop_cycle_r && !call2_r) begin
         sleep_r <= 1'b1;
         wdt_r <= WDT_W'(WATCHDOG_CLEARED);
         post_r <= '0;
         to_r <= 1'b1;
         pd_r <= 1'b0;
      end else begin
         wdt_r <= wdt_r + 1'b1;
         if (&wdt_r) begin
            post_r <= post_r + 1'b1;
         end
      end
   end

   always_comb begin
      prog_counter = pc_r;
      quarter = q_r;
      working_register = w_r;
      status_flags = st_r;
      bank_select_register = bsr_r;
      working_shadow = ws_r;
      flags_shadow = ss_r;
      bank_shadow = bs_r;
      return_stack_top = tos_r;
      watchdog_counter = wdt_r;
      watchdog_postscaler = post_r;
      power_stat.timeout_flag = to_r;
      power_stat.powerdown_flag = pd_r;
      power_stat.sleeping = sleep_r;
      osc_halted = sleep_r;
   end

   quarter_cycle_a: assert property (@(posedge clk) disable iff (!rst_n)
      !sleep_r && q_r == Q_WRITE |=> q_r == Q_DECODE) else $error("quarter did not wrap");
   branch_taken_a: assert property (@(posedge clk) disable iff (!rst_n)
      q_r == Q_WRITE && bz_taken && !nop_cycle_r && !call2_r && !sleep_r
      |=> pc_r == $past(pc_r) + {{12{$past(ir_r[7])}}, $past(ir_r[7:0]), 1'b0})
      else $error("taken branch target wrong");
   branch_nop_a: assert property (@(posedge clk) disable iff (!rst_n)
      q_r == Q_WRITE && bz_taken && !nop_cycle_r && !call2_r && !sleep_r
      |=> nop_cycle_r [*4]) else $error("no nop cycle after branch");
   call_push_a: assert property (@(posedge clk) disable iff (!rst_n)
      q_r == Q_PROCESS && is_call && !call2_r && !nop_cycle_r && !sleep_r
      |=> tos_r == $past(pc_r) - PC_STEP + CALL_RETURN_STEP) else $error("call return address wrong");
   daw_carry_a: assert property (@(posedge clk) disable iff (!rst_n)
      q_r == Q_WRITE && is_daw && !nop_cycle_r && !call2_r && !sleep_r && daw_hi
      |=> st_r[FLAG_C]) else $error("adjust did not set carry");
   dec_write_a: assert property (@(posedge clk) disable iff (!rst_n)
      req.wr |-> is_dec || is_sub) else $error("stray file write");
   read_q2_a: assert property (@(posedge clk) disable iff (!rst_n)
      req.rd |-> q_r == Q_READ) else $error("file read outside q2");
   sleep_flags_a: assert property (@(posedge clk) disable iff (!rst_n)
      $rose(sleep_r) |-> to_r && !pd_r && wdt_r == '0 && post_r == '0)
      else $error("sleep status wrong");
   wake_to_a: assert property (@(posedge clk) disable iff (!rst_n)
      sleep_r && wake_s2_r |=> !to_r && !sleep_r) else $error("watchdog wake kept timeout");
   sleep_freeze_a: assert property (@(posedge clk) disable iff (!rst_n)
      sleep_r && $past(sleep_r) |-> q_r == $past(q_r)) else $error("quarters ran in sleep");
   second_nop_a: assert property (@(posedge clk) disable iff (!rst_n)
      q_r == Q_WRITE && is_second && !nop_cycle_r && !call2_r && !sleep_r
      |=> w_r == $past(w_r) && st_r == $past(st_r)) else $error("lone second word changed state");

   cover_branch_c: cover property (@(posedge clk) disable iff (!rst_n) $rose(nop_cycle_r));
   cover_call_c: cover property (@(posedge clk) disable iff (!rst_n) $rose(call2_r));
   cover_sleep_c: cover property (@(posedge clk) disable iff (!rst_n) $rose(sleep_r));
   cover_write_c: cover property (@(posedge clk) disable iff (!rst_n) req.wr);
endmodule

/* File: test/prog_mem_model.sv */
// program memory model answering instruction words by program counter
`timescale 1ns/1ps
module prog_mem_model #(
   parameter int DEPTH = 512
) (
   input wire logic [20:0] prog_counter,
   output logic [15:0] instr_word
);
   logic [15:0] words [DEPTH];

   // byte address to word index; space past the array reads as nop
   always_comb begin
      if (prog_counter[20:1] < DEPTH) begin
         instr_word = words[prog_counter[9:1]];
      end else begin
         instr_word = 16'h0000;
      end
   end
endmodule

/* File: test/tb_cpu_instr_subset_exec.sv */
// self-checking bench for the instruction subset executor
`timescale 1ns/1ps
module tb_cpu_instr_subset_exec;
   import instr_exec_pkg::*;
   logic clk;
   logic rst_n;
   logic extended_mode;
   logic [11:0] index_base;
   logic watchdog_wake;
   logic other_wake;
   logic [15:0] instr_word;
   logic [20:0] prog_counter;
   quarter_t quarter;
   logic [7:0] working_register;
   logic [4:0] status_flags;
   logic [3:0] bank_select_register;
   logic [7:0] working_shadow;
   logic [4:0] flags_shadow;
   logic [3:0] bank_shadow;
   logic [20:0] return_stack_top;
   logic [7:0] watchdog_counter;
   logic [6:0] watchdog_postscaler;
   power_stat_t power_stat;
   logic osc_halted;
   int errors;
   int checks_done;

   cpu_instr_subset_exec u_cpu_instr_subset_exec (
      .clk, .rst_n, .instr_word, .extended_mode, .index_base, .watchdog_wake, .other_wake,
      .prog_counter, .quarter, .working_register, .status_flags, .bank_select_register,
      .working_shadow, .flags_shadow, .bank_shadow, .return_stack_top, .watchdog_counter,
      .watchdog_postscaler, .power_stat, .osc_halted
   );

   prog_mem_model u_prog_mem_model (
      .prog_counter(prog_counter),
      .instr_word(instr_word)
   );

   initial begin
      clk = 1'b0;
      forever begin
         #5 clk = ~clk;
      end
   end

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         errors++;
         $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic stop_test();
      $display("checks_done=%0d errors=%0d", checks_done, errors);
      if (errors == 0 && checks_done > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   // reset, load three words at address 0, release
   task automatic boot(input logic [15:0] w0, input logic [15:0] w1, input logic [15:0] w2);
      @(posedge clk);
      rst_n <= 1'b0;
      @(posedge clk);
      u_prog_mem_model.words = '{default: 16'h0000};
      u_prog_mem_model.words[0] = w0;
      u_prog_mem_model.words[1] = w1;
      u_prog_mem_model.words[2] = w2;
      @(posedge clk);
      rst_n <= 1'b1;
      #1;
   endtask

   // waits for the edge ending the write quarter
   task automatic next_fetch();
      int n;
      n = 0;
      while (quarter !== Q_WRITE && n < 8) begin
         @(posedge clk);
         #1;
         n++;
      end
      @(posedge clk);
      #1;
   endtask

   task automatic wake(input logic wd);
      int n;
      @(posedge clk);
      watchdog_wake <= wd;
      other_wake <= ~wd;
      n = 0;
      #1;
      while (power_stat.sleeping !== 1'b0 && n < 12) begin
         @(posedge clk);
         #1;
         n++;
      end
      @(posedge clk);
      watchdog_wake <= 1'b0;
      other_wake <= 1'b0;
      #1;
      check(power_stat.sleeping, 1'b0);
   endtask

   task automatic t_reset();
      boot(16'h0000, 16'h0000, 16'h0000);
      check(prog_counter, PC_RESET);
      check(working_register, 8'h00);
      check(status_flags, 5'h00);
      check(return_stack_top, 21'h000000);
      check(power_stat, 3'b110);
      for (int i = 0; i < 4; i++) begin
         check(quarter, i);
         @(posedge clk);
         #1;
      end
   endtask

   // decrement of 00 into w gives FF, then adjust gives 55 with carry
   task automatic t_daw();
      u_cpu_instr_subset_exec.u_ram.mem[16] = 8'h00;
      boot(16'h0410, DECIMAL_ADJUST_WORD, 16'hF123);
      next_fetch();
      next_fetch();
      check(working_register, 8'hFF);
      check(status_flags, 5'h10);
      next_fetch();
      check(working_register, 8'h55);
      check(status_flags, 5'h11);
      check(prog_counter, 21'h000006);
      next_fetch();
      check(working_register, 8'h55);
      check(return_stack_top, 21'h000000);
      check(prog_counter, 21'h000008);
   endtask

   // not taken first, then taken from address 2 to 2+2+10
   task automatic t_branch();
      boot(16'hE005, 16'h0000, 16'h0000);
      check(status_flags[FLAG_Z], 1'b0);
      next_fetch();
      next_fetch();
      check(prog_counter, 21'h000004);
      next_fetch();
      check(prog_counter, 21'h000006);
      u_cpu_instr_subset_exec.u_ram.mem[16] = 8'h01;
      boot(16'h0410, 16'hE005, 16'h5410);
      u_prog_mem_model.words[7] = 16'h5410;
      next_fetch();
      next_fetch();
      check(status_flags, 5'h07);
      next_fetch();
      check(prog_counter, 21'h00000E);
      next_fetch();
      check(working_register, 8'h00);
      check(prog_counter, 21'h000010);
      next_fetch();
      check(working_register, 8'hFF);
      check(status_flags, 5'h10);
   endtask

   task automatic t_call();
      logic [19:0] k;
      k = 20'h00123;
      u_cpu_instr_subset_exec.u_ram.mem[16] = 8'h00;
      boot(16'h0410, {CALL_HI7, 1'b1, k[7:0]}, {SECOND_WORD_HI, k[19:8]});
      next_fetch();
      next_fetch();
      next_fetch();
      check(prog_counter, {k, 1'b0});
      check(return_stack_top, 21'h000002 + CALL_RETURN_STEP);
      check(working_shadow, 8'hFF);
      check(flags_shadow, 5'h10);
      check(bank_shadow, 4'h0);
      next_fetch();
      check(prog_counter, {k, 1'b0} + PC_STEP);
   endtask

   // extended mode: address 10 lands at index base 100 plus 10
   task automatic t_file();
      u_cpu_instr_subset_exec.u_ram.mem[12'h010] = 8'hAA;
      u_cpu_instr_subset_exec.u_ram.mem[12'h110] = 8'h01;
      @(posedge clk);
      extended_mode <= 1'b1;
      index_base <= 12'h100;
      boot(16'h0610, 16'h0410, 16'h5410);
      next_fetch();
      next_fetch();
      check(working_register, 8'h00);
      check(status_flags, 5'h07);
      check(prog_counter, 21'h000004);
      next_fetch();
      check(working_register, 8'hFF);
      next_fetch();
      check(working_register, 8'hFE);
      check(status_flags, 5'h13);
      check(prog_counter, 21'h000008);
      check(u_cpu_instr_subset_exec.u_ram.mem[12'h010], 8'hAA);
      @(posedge clk);
      extended_mode <= 1'b0;
   endtask

   task automatic t_sleep();
      logic [20:0] pc0;
      quarter_t q0;
      int n;
      boot(SLEEP_WORD, SLEEP_WORD, 16'h0000);
      next_fetch();
      repeat (4) @(posedge clk);
      #1;
      check(watchdog_counter, WATCHDOG_CLEARED);
      check(watchdog_postscaler, 7'h00);
      check(power_stat, 3'b101);
      check(osc_halted, 1'b1);
      pc0 = prog_counter;
      q0 = quarter;
      repeat (20) @(posedge clk);
      #1;
      check(prog_counter, pc0);
      check(quarter, q0);
      wake(1'b1);
      check(power_stat.timeout_flag, 1'b0);
      n = 0;
      while (power_stat.sleeping !== 1'b1 && n < 12) begin
         @(posedge clk);
         #1;
         n++;
      end
      check(power_stat, 3'b101);
      wake(1'b0);
      check(power_stat.timeout_flag, 1'b1);
   endtask

   initial begin
      #100000;
      errors++;
      stop_test();
   end

   initial begin
      errors = 0;
      checks_done = 0;
      rst_n = 1'b0;
      extended_mode = 1'b0;
      index_base = 12'h000;
      watchdog_wake = 1'b0;
      other_wake = 1'b0;
      repeat (16) @(posedge clk);
      t_reset();
      t_daw();
      t_branch();
      t_call();
      t_file();
      t_sleep();
      stop_test();
   end
endmodule
